// file: hw/ssm_top.v
// sync mode configuration and receive sync strip logic for one channel
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`include "ssm_defs.vh"
module ssm_top #(
  parameter ADDR_W = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [ADDR_W-1:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire line_clk,
  input wire rx_data,
  input wire sync_pin_n,
  output reg rx_enable,
  output reg sync_mode,
  output reg [1:0] stop_bits,
  output reg [6:0] clk_ratio,
  output reg sdlc_mode,
  output reg [15:0] tx_fill,
  output reg tx_fill_16,
  output reg tx_fill_6,
  output reg rx_sync_hit,
  output reg rx_byte_valid,
  output reg [7:0] rx_byte,
  output reg rx_crc_en,
  output reg addr_match
);
  reg [7:0] rx_ctrl_q;
  reg [7:0] mode_q;
  reg [7:0] fill_q;
  reg [7:0] pat_q;
  reg [7:0] line_q;
  reg [7:0] clk_sel_q;
  reg wr_pend_q;
  reg [ADDR_W-1:0] wr_addr_q;
  reg [2:0] clk_sync_q;
  reg [1:0] dat_sync_q;
  reg [1:0] pin_sync_q;
  reg [15:0] shift_q;
  reg [3:0] bit_cnt_q;
  reg hunt_q;
  reg first_q;
  reg pend_sync_q;
  reg [7:0] pend_byte_q;
  reg [1:0] chan_rst_q;
  reg [7:0] held_byte_q;
  reg [1:0] held_cnt_q;
  wire chan_rst;
  wire [1:0] sync_sel;
  wire [1:0] clk_code;
  wire is_sync;
  wire is_ext;
  wire is_sdlc;
  wire six_bit;
  wire strip_ok;
  wire rise;
  wire pin_sync;
  wire [7:0] new_byte;
  wire pat_hit;
  wire [15:0] shift_d;
  wire flag_hit;
  wire [7:0] rd_val;
  function sel;
    input [ADDR_W-1:0] a;
    input [7:0] off;
    begin
      sel = (a[7:0] == off);
    end
  endfunction
  // hunt exit decision for every sync mode
  function sync_found;
    input ext;
    input sdlc;
    input sync;
    input [1:0] code;
    input pin;
    input pat;
    input flag;
    begin
      sync_found = (ext && (pin || (code == 2'h2 && pat))) ||
        (sdlc && !ext && flag) ||
        (sync && !ext && !sdlc && pat);
    end
  endfunction
  assign chan_rst = chan_rst_q[0];
  assign sync_sel = mode_q[`SSM_SYNC_LSB+1:`SSM_SYNC_LSB];
  assign clk_code = mode_q[`SSM_CLK_LSB+1:`SSM_CLK_LSB];
  assign is_sync = (mode_q[`SSM_STOP_LSB+1:`SSM_STOP_LSB] == `SSM_STOP_SYNC);
  assign is_ext = is_sync && (sync_sel == `SSM_SYNC_EXT);
  assign is_sdlc = is_sync && ((sync_sel == `SSM_SYNC_SDLC) || (is_ext && clk_code == 2'h3));
  assign six_bit = line_q[`SSM_SIX_BIT_BIT];
  assign strip_ok = rx_ctrl_q[`SSM_STRIP_BIT] && is_sync && !is_sdlc &&
    !(sync_sel == `SSM_SYNC_BI && six_bit);
  assign pin_sync = !pin_sync_q[1] && !clk_sel_q[`SSM_XTAL_BIT];
  assign rise = clk_sync_q[1] && !clk_sync_q[2];
  assign shift_d = {dat_sync_q[1], shift_q[15:1]};
  assign new_byte = shift_d[15:8];
  assign pat_hit = (sync_sel == `SSM_SYNC_BI) ?
    (six_bit ? (shift_d[15:4] == {pat_q[3:0], fill_q}) : (shift_d == {pat_q, fill_q})) :
    (six_bit ? (shift_d[15:10] == pat_q[5:0]) : (new_byte == pat_q));
  assign flag_hit = (new_byte == pat_q);
  assign rd_val = sel(haddr, `SSM_OFF_STATUS) ? {4'h0, first_q, hunt_q, rx_sync_hit, rx_enable} :
    8'h00;
  // bus write data phase and register file
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= {ADDR_W{1'b0}};
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      rx_ctrl_q <= `SSM_RST_RX_CTRL;
      mode_q <= `SSM_RST_MODE;
      fill_q <= `SSM_RST_BYTE;
      pat_q <= `SSM_RST_BYTE;
      line_q <= `SSM_RST_BYTE;
      clk_sel_q <= `SSM_RST_BYTE;
      chan_rst_q <= 2'h0;
    end
    else
    begin
      chan_rst_q <= {1'b0, chan_rst_q[1]};
      if (hready)
      begin
        wr_pend_q <= hsel && htrans[1] && hwrite;
        wr_addr_q <= haddr;
        hrdata <= (hsel && htrans[1] && !hwrite) ? {24'h000000, rd_val} : 32'h00000000;
      end
      if (chan_rst)
      begin
        rx_ctrl_q <= `SSM_RST_RX_CTRL;
        mode_q <= `SSM_RST_MODE;
      end
      else if (wr_pend_q)
      begin
        if (sel(wr_addr_q, `SSM_OFF_RX_CTRL))
          rx_ctrl_q <= hwdata[7:0];
        if (sel(wr_addr_q, `SSM_OFF_MODE))
          mode_q <= hwdata[7:0];
        if (sel(wr_addr_q, `SSM_OFF_TX_FILL))
          fill_q <= hwdata[7:0];
        if (sel(wr_addr_q, `SSM_OFF_RX_PAT))
          pat_q <= hwdata[7:0];
        if (sel(wr_addr_q, `SSM_OFF_LINE_CTRL))
          line_q <= hwdata[7:0];
        if (sel(wr_addr_q, `SSM_OFF_CLK_SEL))
          clk_sel_q <= hwdata[7:0];
        if (sel(wr_addr_q, `SSM_OFF_CTRL) && hwdata[0])
          chan_rst_q <= 2'h3;
      end
    end
  end
  // decoded configuration outputs
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_enable <= 1'b0;
      sync_mode <= 1'b0;
      stop_bits <= 2'h0;
      clk_ratio <= 7'h01;
      sdlc_mode <= 1'b0;
      tx_fill <= 16'h0000;
      tx_fill_16 <= 1'b0;
      tx_fill_6 <= 1'b0;
    end
    else
    begin
      rx_enable <= rx_ctrl_q[`SSM_RX_EN_BIT];
      sync_mode <= is_sync;
      stop_bits <= mode_q[`SSM_STOP_LSB+1:`SSM_STOP_LSB];
      if (is_sync && !is_ext)
        clk_ratio <= 7'h01;
      else
        case (clk_code)
          2'h0: clk_ratio <= 7'h01;
          2'h1: clk_ratio <= 7'h10;
          2'h2: clk_ratio <= 7'h20;
          2'h3: clk_ratio <= 7'h40;
          default: clk_ratio <= 7'h01;
        endcase
      sdlc_mode <= is_sdlc;
      tx_fill <= (is_sync && sync_sel == `SSM_SYNC_BI) ? {pat_q, fill_q} : {8'h00, fill_q};
      tx_fill_16 <= is_sync && sync_sel == `SSM_SYNC_BI;
      tx_fill_6 <= six_bit && !(sync_sel == `SSM_SYNC_BI);
    end
  end
  // line sampling and receive path
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clk_sync_q <= 3'h0;
      dat_sync_q <= 2'h0;
      pin_sync_q <= 2'h3;
      shift_q <= 16'h0000;
      bit_cnt_q <= 4'h0;
      hunt_q <= 1'b1;
      first_q <= 1'b1;
      pend_sync_q <= 1'b0;
      pend_byte_q <= 8'h00;
      held_byte_q <= 8'h00;
      held_cnt_q <= 2'h0;
      rx_sync_hit <= 1'b0;
      rx_byte_valid <= 1'b0;
      rx_byte <= 8'h00;
      rx_crc_en <= 1'b0;
      addr_match <= 1'b0;
    end
    else
    begin
      clk_sync_q <= {clk_sync_q[1:0], line_clk};
      dat_sync_q <= {dat_sync_q[0], rx_data};
      pin_sync_q <= {pin_sync_q[0], sync_pin_n};
      rx_sync_hit <= 1'b0;
      rx_byte_valid <= 1'b0;
      rx_crc_en <= 1'b0;
      // release data byte held behind kept sync
      if (held_cnt_q != 2'h0)
        held_cnt_q <= held_cnt_q - 2'h1;
      if (held_cnt_q == 2'h1)
      begin
        rx_byte_valid <= 1'b1;
        rx_byte <= held_byte_q;
        rx_crc_en <= 1'b1;
      end
      if (!rx_enable || chan_rst)
      begin
        hunt_q <= 1'b1;
        first_q <= 1'b1;
        pend_sync_q <= 1'b0;
        held_cnt_q <= 2'h0;
        bit_cnt_q <= 4'h0;
      end
      else if (rise)
      begin
        shift_q <= shift_d;
        if (hunt_q)
        begin
          // pin at any clock ratio, receive pattern also accepted at 32x
          if (sync_found(is_ext, is_sdlc, is_sync, clk_code, pin_sync, pat_hit, flag_hit))
          begin
            hunt_q <= 1'b0;
            rx_sync_hit <= 1'b1;
            bit_cnt_q <= 4'h0;
          end
        end
        else if (bit_cnt_q == 4'h7)
        begin
          bit_cnt_q <= 4'h0;
          if (is_sdlc && (flag_hit || (is_ext && pin_sync)))
            first_q <= 1'b1;
          else if (is_sdlc && first_q && rx_ctrl_q[`SSM_ADDR_SRCH_BIT])
          begin
            first_q <= 1'b0;
            if (rx_ctrl_q[`SSM_STRIP_BIT])
              addr_match <= (new_byte[7:4] == fill_q[7:4]);
            else
              addr_match <= (new_byte == fill_q);
            rx_byte_valid <= 1'b1;
            rx_byte <= new_byte;
            rx_crc_en <= 1'b1;
          end
          else if (strip_ok && new_byte == fill_q)
          begin
            pend_sync_q <= six_bit;
            pend_byte_q <= new_byte;
          end
          else if (pend_sync_q)
          begin
            pend_sync_q <= 1'b0;
            rx_byte_valid <= 1'b1;
            rx_byte <= pend_byte_q;
            rx_crc_en <= 1'b1;
            first_q <= 1'b0;
            // data byte follows two cycles later
            held_byte_q <= new_byte;
            held_cnt_q <= 2'h2;
          end
          else
          begin
            first_q <= 1'b0;
            rx_byte_valid <= 1'b1;
            rx_byte <= new_byte;
            rx_crc_en <= 1'b1;
          end
        end
        else
          bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end
  end
endmodule

// file: hw/ssm_defs.vh
// constants for the sync mode configuration block
`ifndef SSM_DEFS_VH
`define SSM_DEFS_VH
`define SSM_OFF_RX_CTRL 8'h00
`define SSM_OFF_MODE 8'h04
`define SSM_OFF_TX_FILL 8'h08
`define SSM_OFF_RX_PAT 8'h0C
`define SSM_OFF_LINE_CTRL 8'h10
`define SSM_OFF_CLK_SEL 8'h14
`define SSM_OFF_STATUS 8'h18
`define SSM_OFF_CTRL 8'h1C
`define SSM_RX_EN_BIT 0
`define SSM_STRIP_BIT 1
`define SSM_ADDR_SRCH_BIT 2
`define SSM_STOP_LSB 2
`define SSM_SYNC_LSB 4
`define SSM_CLK_LSB 6
`define SSM_SIX_BIT_BIT 0
`define SSM_XTAL_BIT 7
`define SSM_RST_RX_CTRL 8'h00
`define SSM_RST_MODE 8'h04
`define SSM_RST_BYTE 8'h00
`define SSM_SYNC_MONO 2'h0
`define SSM_SYNC_BI 2'h1
`define SSM_SYNC_SDLC 2'h2
`define SSM_SYNC_EXT 2'h3
`define SSM_STOP_SYNC 2'h0
`define SSM_STOP_ONE 2'h1
`define SSM_STOP_ONE_HALF 2'h2
`define SSM_STOP_TWO 2'h3
`endif

// file: verif/ssm_chk.sv
// assertion checker for the sync mode configuration block
module ssm_chk (
  input logic hclk,
  input logic hresetn,
  input logic hreadyout,
  input logic hresp,
  input logic rx_enable,
  input logic sync_mode,
  input logic [1:0] stop_bits,
  input logic [6:0] clk_ratio,
  input logic sdlc_mode,
  input logic rx_byte_valid,
  input logic rx_crc_en,
  input logic rx_sync_hit
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] up_q;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      up_q <= 2'h0;
    else if (up_q != 2'h3)
      up_q <= up_q + 2'h1;
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_reset_mode: assert property (up_q == 2'h2 |-> stop_bits == 2'h1 && !rx_enable)
    else $error("mode not at reset value");
  a_sync_stop: assert property (up_q == 2'h3 |-> sync_mode == (stop_bits == 2'h0))
    else $error("sync_mode disagrees with stop field");
  a_ratio_legal: assert property (clk_ratio inside {7'h01, 7'h10, 7'h20, 7'h40})
    else $error("illegal clock ratio");
  a_sdlc_ratio: assert property (sync_mode && sdlc_mode |-> clk_ratio inside {7'h01, 7'h40})
    else $error("sdlc ratio wrong");
  a_crc_byte: assert property (rx_crc_en |-> rx_byte_valid)
    else $error("crc without byte");
  a_byte_pulse: assert property (rx_byte_valid |=> !rx_byte_valid) else $error("byte pulse long");
  a_sync_pulse: assert property (rx_sync_hit |=> !rx_sync_hit) else $error("sync pulse long");
  a_rx_off: assert property (!rx_enable [*4] |-> !rx_byte_valid)
    else $error("byte while disabled");
  c_byte: cover property (rx_byte_valid);
  c_sync: cover property (rx_sync_hit);
  c_sdlc: cover property (sync_mode && sdlc_mode);
endmodule

// file: verif/ssm_line_model.sv
// remote line station driving the serial receive line
module ssm_line_model (
  output logic line_clk,
  output logic rx_data,
  output logic sync_pin_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    line_clk = 1'b0;
    rx_data = 1'b1;
    sync_pin_n = 1'b1;
  end
  // lsb first; clock rests low between frames, data shows inverse when idle
  task automatic send_byte(input logic [7:0] b);
    #1.3;
    for (int i = 0; i < 8; i++)
    begin
      rx_data = b[i];
      #40 line_clk = 1'b1;
      #40 line_clk = 1'b0;
    end
    rx_data = ~b[7];
  endtask
endmodule

// file: verif/ssm_top_bench.sv
// self-checking bench for the sync mode configuration block
module ssm_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk, hresetn, hsel, hwrite, line_clk, rx_data, sync_pin_n, hreadyout, hresp;
  logic rx_enable, sync_mode, sdlc_mode, tx_fill_16, tx_fill_6, rx_sync_hit;
  logic rx_byte_valid, rx_crc_en, addr_match;
  logic [1:0] htrans, stop_bits;
  logic [2:0] hsize;
  logic [6:0] clk_ratio;
  logic [15:0] tx_fill;
  logic [31:0] hwdata, hrdata, rd;
  logic [7:0] haddr, rx_byte, last_q, fill, dat, m;
  int errors, checked, nfill, nbyte, ncrc;
  integer seed = 32'h0869888E;
  ssm_top #(.ADDR_W(8)) ssm_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .line_clk(line_clk), .rx_data(rx_data), .sync_pin_n(sync_pin_n),
    .rx_enable(rx_enable), .sync_mode(sync_mode), .stop_bits(stop_bits),
    .clk_ratio(clk_ratio), .sdlc_mode(sdlc_mode), .tx_fill(tx_fill),
    .tx_fill_16(tx_fill_16), .tx_fill_6(tx_fill_6), .rx_sync_hit(rx_sync_hit),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_crc_en(rx_crc_en),
    .addr_match(addr_match));
  ssm_line_model ssm_line_model_inst (.line_clk(line_clk), .rx_data(rx_data),
    .sync_pin_n(sync_pin_n));
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk)
    if (rx_byte_valid === 1'b1)
    begin
      nbyte++;
      last_q <= rx_byte;
      nfill += (rx_byte === fill);
      ncrc += (rx_crc_en === 1'b1);
    end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      errors++;
      stop_test;
    end
  endtask
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    r = hrdata;
  endtask
  function automatic logic [10:0] expm(input logic [7:0] v);
    logic sy;
    logic [6:0] ra;
    sy = (v[3:2] == 2'h0);
    ra = (v[7:6] == 2'h0) ? 7'h01 : (v[7:6] == 2'h1) ? 7'h10 : (v[7:6] == 2'h2) ? 7'h20 : 7'h40;
    if (sy && v[5:4] != 2'h3)
      ra = 7'h01;
    return {sy, v[3:2], ra, sy && (v[5:4] == 2'h2 || v[7:4] == 4'hF)};
  endfunction
  initial
  begin
    {hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
    hresetn = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    check(stop_bits, 2'h1);
    check(rx_enable, 1'b0);
    for (int i = 0; i < 24; i++)
    begin
      m = $random(seed);
      if (i < 16)
        m = {i[3:0], 2'h0, m[1:0]};
      if (m[3:2] == 2'h2 && m[7:6] == 2'h0)
        m[7:6] = 2'h1;
      ahb(8'h04, 1'b1, m, rd);
      repeat (3) @(posedge hclk);
      check({sync_mode, stop_bits, clk_ratio, sdlc_mode}, expm(m));
    end
    fill = $random(seed) | 8'h80;
    dat = fill ^ 8'h41;
    ahb(8'h08, 1'b1, fill, rd);
    ahb(8'h0C, 1'b1, 8'h3C, rd);
    ahb(8'h04, 1'b1, 8'h00, rd);
    ahb(8'h10, 1'b1, 8'h00, rd);
    ahb(8'h00, 1'b1, 8'h03, rd);
    check({tx_fill_16, tx_fill}, {1'b0, 8'h00, fill});
    {nfill, nbyte, ncrc} = '0;
    ssm_line_model_inst.send_byte(8'h3C);
    ssm_line_model_inst.send_byte(fill);
    ssm_line_model_inst.send_byte(dat);
    ssm_line_model_inst.send_byte(fill);
    repeat (20) @(posedge hclk);
    check(nfill, 0);
    check(last_q, dat);
    check(ncrc, nbyte);
    ahb(8'h00, 1'b1, 8'h01, rd);
    ssm_line_model_inst.send_byte(fill);
    repeat (20) @(posedge hclk);
    check(last_q, fill);
    ahb(8'h00, 1'b1, 8'h00, rd);
    ahb(8'h0C, 1'b1, 8'h1F, rd);
    ahb(8'h10, 1'b1, 8'h01, rd);
    ahb(8'h00, 1'b1, 8'h03, rd);
    check(tx_fill_6, 1'b1);
    {nfill, nbyte, ncrc} = '0;
    ssm_line_model_inst.send_byte(8'hFF);
    ssm_line_model_inst.send_byte(8'h7F);
    ssm_line_model_inst.send_byte(fill);
    ssm_line_model_inst.send_byte(fill);
    ssm_line_model_inst.send_byte(dat);
    repeat (20) @(posedge hclk);
    check(nbyte, 2);
    check(nfill, 1);
    check(last_q, dat);
    check(ncrc, nbyte);
    ahb(8'h1C, 1'b1, 8'h01, rd);
    repeat (4) @(posedge hclk);
    check(rx_enable, 1'b0);
    check(stop_bits, 2'h1);
    ahb(8'h18, 1'b0, 32'h0, rd);
    check(rd, 32'h0000000C);
    ahb(8'h04, 1'b0, 32'h0, rd);
    check(rd, 32'h0);
    ahb(8'h40, 1'b0, 32'h0, rd);
    check(rd, 32'h0);
    // flag to receive pattern, station address kept in fill
    ahb(8'h04, 1'b1, 8'h20, rd);
    ahb(8'h0C, 1'b1, 8'h7E, rd);
    ahb(8'h10, 1'b1, 8'h00, rd);
    ahb(8'h00, 1'b1, 8'h07, rd);
    m = {fill[7:4], ~fill[3:0]};
    ssm_line_model_inst.send_byte(8'hFF);
    ssm_line_model_inst.send_byte(8'h7E);
    ssm_line_model_inst.send_byte(m);
    repeat (20) @(posedge hclk);
    check(addr_match, 1'b1);
    check(last_q, m);
    ahb(8'h00, 1'b1, 8'h05, rd);
    ssm_line_model_inst.send_byte(8'h7E);
    ssm_line_model_inst.send_byte(m);
    repeat (20) @(posedge hclk);
    check(addr_match, 1'b0);
    ahb(8'h00, 1'b1, 8'h03, rd);
    ssm_line_model_inst.send_byte(8'h7E);
    ssm_line_model_inst.send_byte(fill);
    repeat (20) @(posedge hclk);
    check(last_q, fill);
    ahb(8'h04, 1'b1, 8'h10, rd);
    repeat (3) @(posedge hclk);
    check({tx_fill_16, tx_fill}, {1'b1, 8'h7E, fill});
    stop_test;
  end
endmodule
bind ssm_top ssm_chk ssm_chk_inst (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .rx_enable(rx_enable), .sync_mode(sync_mode), .stop_bits(stop_bits),
  .clk_ratio(clk_ratio), .sdlc_mode(sdlc_mode), .rx_byte_valid(rx_byte_valid),
  .rx_crc_en(rx_crc_en), .rx_sync_hit(rx_sync_hit));
